// File: pkg/ccpu_pkg.sv
/*
 package for the capture/compare/pwm unit: register indices and byte
 addresses, mode encodings, field positions, reset values and bus codes.
 assumes a 32-bit axi4-lite register bus with one aligned word per register.
*/
package ccpu_pkg;
   // register indices as printed, byte address is four times the index
   localparam logic [7:0] IDX_VALUE_LOW = 8'h15;
   localparam logic [7:0] IDX_VALUE_HIGH = 8'h16;
   localparam logic [7:0] IDX_MODE_CTL = 8'h17;
   localparam logic [7:0] IDX_FLAG_STATUS = 8'h18;
   localparam logic [9:0] ADDR_VALUE_LOW = {IDX_VALUE_LOW, 2'h0};
   localparam logic [9:0] ADDR_VALUE_HIGH = {IDX_VALUE_HIGH, 2'h0};
   localparam logic [9:0] ADDR_MODE_CTL = {IDX_MODE_CTL, 2'h0};
   localparam logic [9:0] ADDR_FLAG_STATUS = {IDX_FLAG_STATUS, 2'h0};
   localparam int ADDR_W = 10;

   // mode field encodings
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_SET = 4'h8;
   localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
   localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
   localparam logic [3:0] MODE_CMP_TRIG = 4'hB;

   // mode control and flag field positions and reset values
   localparam int POS_MODE_LSB = 0;
   localparam int POS_DUTY_LSB = 4;
   localparam int POS_FLAG = 0;
   localparam logic [7:0] RST_MODE_CTL = 8'h00;
   localparam logic [7:0] RST_VALUE_BYTE = 8'h00;

   // prescaler terminal counts
   localparam logic [1:0] PRE4_LAST = 2'h3;
   localparam logic [3:0] PRE16_LAST = 4'hF;

   // axi response codes
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] duty_lsb;
      logic [3:0] mode;
   } ccpu_mode_ctl_type;

   typedef enum logic [1:0] {
      KIND_OFF,
      KIND_CAPTURE,
      KIND_COMPARE,
      KIND_PWM
   } ccpu_kind_type;
endpackage

// File: rtl/ccpu_top.sv
/*
 capture/compare/pwm unit with an axi4-lite register slave.
 assumes the 16-bit and 8-bit timebases, the port direction bit and the
 port data latch live outside and are synchronous to CLK_SYS.
*/
// What this block does
// - value is two 8-bit bytes; both bytes and mode control are read/write
// - mode 0000 turns the unit off and resets prescaler and output latch
// - modes 0100/0101/0110/0111 capture on fall, rise, 4th rise, 16th rise
// - capture copies the 16-bit timebase into the value pair and sets flag
// - hardware never clears the event flag; only a software write does
// - a later capture overwrites an unread value
// - prescaler is held clear when off or not in capture mode
// - switching between capture prescales keeps the prescaler count
// - the edge detector watches the pad level, even when port drives it
// - compare runs continuously and sets the flag on every match
// - compare match drives latch high in 1000, low in 1001
// - mode 1010 match sets only the flag, output untouched
// - mode 1011 match sets flag and pulses the special event trigger
// - in mode 1011 the value pair acts as the timebase period
// - writing mode control to all zeros forces the output latch low
// - modes 11xx are pwm; duty is low byte plus mode bits 5-4
// - pwm gives up to 10-bit resolution timed from the 8-bit timebase
// - at period end set pin unless duty zero, latch duty into high byte
// - pin clears when latched duty equals timebase with two low bits
// - in pwm mode the high value byte is read-only
`timescale 1ns/10ps
module ccpu_top (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // axi4-lite write address and data
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [ccpu_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   // axi4-lite write response
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   output logic [1:0] S_AXI_BRESP,
   // axi4-lite read
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   input wire logic [ccpu_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   // timebases
   input wire logic [15:0] TB16_COUNT,
   input wire logic [7:0] TB8_COUNT,
   input wire logic [7:0] TB8_PERIOD,
   input wire logic TB8_TICK,
   input wire logic [1:0] TB8_SUBCOUNT,
   // port side
   input wire logic PORT_DIR_INPUT,
   input wire logic PORT_DATA,
   // unit pin, three signals
   input wire logic UNIT_PIN_IN,
   output logic UNIT_PIN_OUT,
   output logic UNIT_PIN_OE_N,
   // events
   output logic SPECIAL_TRIGGER,
   output logic EVENT_FLAG
);
   // register state
   logic [7:0] value_low_byte;
   logic [7:0] value_high_byte;
   ccpu_pkg::ccpu_mode_ctl_type mode_ctl;
   logic [1:0] duty_latch;
   logic unit_event_flag;
   logic out_latch;
   logic [3:0] prescale_cnt;
   logic [2:0] pin_sync;
   logic cmp_match_d;
   // bus state
   logic aw_held;
   logic w_held;
   logic [ccpu_pkg::ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   // mode decode
   wire logic [3:0] mode = mode_ctl.mode;
   wire ccpu_pkg::ccpu_kind_type kind =
      (mode[3:2] == 2'h3) ? ccpu_pkg::KIND_PWM :
      (mode[3:2] == 2'h2) ? ccpu_pkg::KIND_COMPARE :
      (mode[3:2] == 2'h1) ? ccpu_pkg::KIND_CAPTURE : ccpu_pkg::KIND_OFF;
   wire logic is_capture = (kind == ccpu_pkg::KIND_CAPTURE);
   wire logic is_compare = (kind == ccpu_pkg::KIND_COMPARE);
   wire logic is_pwm = (kind == ccpu_pkg::KIND_PWM);

   // write side: both halves held, no response pending
   wire logic aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
   wire logic w_take = S_AXI_WVALID & S_AXI_WREADY;
   wire logic wr_fire = aw_held & w_held & ~S_AXI_BVALID;
   wire logic wr_lane = wr_fire & w_strb[0];
   wire logic wr_low = wr_lane & (aw_addr == ccpu_pkg::ADDR_VALUE_LOW);
   wire logic wr_high = wr_lane & (aw_addr == ccpu_pkg::ADDR_VALUE_HIGH) & ~is_pwm;
   wire logic wr_mode = wr_lane & (aw_addr == ccpu_pkg::ADDR_MODE_CTL);
   wire logic wr_flag = wr_lane & (aw_addr == ccpu_pkg::ADDR_FLAG_STATUS);
   wire logic wr_mapped = (aw_addr == ccpu_pkg::ADDR_VALUE_LOW) |
      (aw_addr == ccpu_pkg::ADDR_VALUE_HIGH) | (aw_addr == ccpu_pkg::ADDR_MODE_CTL) |
      (aw_addr == ccpu_pkg::ADDR_FLAG_STATUS);
   wire logic mode_zero_write = wr_mode & (w_data[7:0] == 8'h00);

   // read side decode
   wire logic ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
   wire logic rd_low = (S_AXI_ARADDR == ccpu_pkg::ADDR_VALUE_LOW);
   wire logic rd_high = (S_AXI_ARADDR == ccpu_pkg::ADDR_VALUE_HIGH);
   wire logic rd_mode = (S_AXI_ARADDR == ccpu_pkg::ADDR_MODE_CTL);
   wire logic rd_flag = (S_AXI_ARADDR == ccpu_pkg::ADDR_FLAG_STATUS);
   wire logic rd_mapped = rd_low | rd_high | rd_mode | rd_flag;
   wire logic [7:0] rd_byte =
      rd_low ? value_low_byte :
      rd_high ? value_high_byte :
      rd_mode ? {2'h0, mode_ctl} :
      rd_flag ? {7'h00, unit_event_flag} : 8'h00;

   // capture: synchronised pad level, edge detect, prescaler
   wire logic pin_rise = pin_sync[1] & ~pin_sync[2];
   wire logic pin_fall = ~pin_sync[1] & pin_sync[2];
   wire logic pre_count = is_capture & mode[1] & pin_rise;
   wire logic cap_event = is_capture & (
      ((mode == ccpu_pkg::MODE_CAP_FALL) & pin_fall) |
      ((mode == ccpu_pkg::MODE_CAP_RISE) & pin_rise) |
      ((mode == ccpu_pkg::MODE_CAP_RISE4) & pin_rise &
         (prescale_cnt[1:0] == ccpu_pkg::PRE4_LAST)) |
      ((mode == ccpu_pkg::MODE_CAP_RISE16) & pin_rise &
         (prescale_cnt == ccpu_pkg::PRE16_LAST)));
   wire logic [3:0] next_prescale =
      (~is_capture | (wr_mode & (w_data[3:2] != 2'h1))) ? 4'h0 :
      pre_count ? prescale_cnt + 4'h1 : prescale_cnt;

   // compare: continuous equality, act on its first cycle
   wire logic cmp_match = is_compare & ({value_high_byte, value_low_byte} == TB16_COUNT);
   wire logic cmp_event = cmp_match & ~cmp_match_d;
   wire logic trig_event = cmp_event & (mode == ccpu_pkg::MODE_CMP_TRIG);

   // pwm: period end and duty match
   wire logic period_end = is_pwm & TB8_TICK & (TB8_COUNT == TB8_PERIOD);
   wire logic [9:0] duty_buffered = {value_low_byte, mode_ctl.duty_lsb};
   wire logic duty_hit = is_pwm & ({value_high_byte, duty_latch} ==
      {TB8_COUNT, TB8_SUBCOUNT});

   // unit output latch
   wire logic next_out_latch =
      (mode_zero_write | (kind == ccpu_pkg::KIND_OFF)) ? 1'b0 :
      period_end ? (duty_buffered != 10'h000) :
      duty_hit ? 1'b0 :
      (cmp_event & (mode == ccpu_pkg::MODE_CMP_SET)) ? 1'b1 :
      (cmp_event & (mode == ccpu_pkg::MODE_CMP_CLEAR)) ? 1'b0 :
      out_latch;

   // pin drive: unit latch in compare and pwm, port data latch otherwise
   wire logic next_pin_out = (is_compare | is_pwm) ? next_out_latch : PORT_DATA;

   // event flag: set wins over the software clear
   wire logic flag_set = cap_event | cmp_event;
   wire logic next_flag = flag_set | (unit_event_flag &
      ~(wr_flag & w_data[ccpu_pkg::POS_FLAG]));

   // value bytes: capture wins over a software write in the same cycle
   wire logic [7:0] next_low = cap_event ? TB16_COUNT[7:0] :
      wr_low ? w_data[7:0] : value_low_byte;
   wire logic [7:0] next_high = cap_event ? TB16_COUNT[15:8] :
      period_end ? value_low_byte :
      wr_high ? w_data[7:0] : value_high_byte;

   // mode control and internal duty latch
   wire ccpu_pkg::ccpu_mode_ctl_type next_mode_ctl =
      wr_mode ? w_data[5:0] : mode_ctl;
   wire logic [1:0] next_duty_latch =
      (kind == ccpu_pkg::KIND_OFF) ? 2'h0 :
      period_end ? mode_ctl.duty_lsb : duty_latch;

   // synchroniser and edge history
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
         pin_sync <= 3'h0;
      else
         pin_sync <= {pin_sync[1:0], UNIT_PIN_IN};
   end

   // unit registers
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         value_low_byte <= ccpu_pkg::RST_VALUE_BYTE;
         value_high_byte <= ccpu_pkg::RST_VALUE_BYTE;
         mode_ctl <= ccpu_pkg::RST_MODE_CTL[5:0];
         duty_latch <= 2'h0;
         unit_event_flag <= 1'b0;
         out_latch <= 1'b0;
         prescale_cnt <= 4'h0;
         cmp_match_d <= 1'b0;
      end
      else
      begin
         value_low_byte <= next_low;
         value_high_byte <= next_high;
         mode_ctl <= next_mode_ctl;
         duty_latch <= next_duty_latch;
         unit_event_flag <= next_flag;
         out_latch <= next_out_latch;
         prescale_cnt <= next_prescale;
         cmp_match_d <= cmp_match;
      end
   end

   // registered outputs
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         UNIT_PIN_OUT <= 1'b0;
         UNIT_PIN_OE_N <= 1'b1;
         SPECIAL_TRIGGER <= 1'b0;
         EVENT_FLAG <= 1'b0;
      end
      else
      begin
         UNIT_PIN_OUT <= next_pin_out;
         UNIT_PIN_OE_N <= PORT_DIR_INPUT; // low while driving
         SPECIAL_TRIGGER <= trig_event;
         EVENT_FLAG <= next_flag;
      end
   end

   // write address and data capture
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY <= 1'b0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         else if (wr_fire)
            aw_held <= 1'b0;
         if (w_take)
         begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         else if (wr_fire)
            w_held <= 1'b0;
         S_AXI_AWREADY <= ~aw_held & ~aw_take & ~S_AXI_BVALID;
         S_AXI_WREADY <= ~w_held & ~w_take & ~S_AXI_BVALID;
      end
   end

   // write response
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= ccpu_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         S_AXI_BVALID <= 1'b1;
         S_AXI_BRESP <= wr_mapped ? ccpu_pkg::RESP_OKAY : ccpu_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
         S_AXI_BVALID <= 1'b0;
   end

   // read channel
   always_ff @(posedge CLK_SYS)
   begin
      if (SRST)
      begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= ccpu_pkg::RESP_OKAY;
      end
      else
      begin
         S_AXI_ARREADY <= ~S_AXI_RVALID & ~ar_take;
         if (ar_take)
         begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA <= {24'h000000, rd_byte};
            S_AXI_RRESP <= rd_mapped ? ccpu_pkg::RESP_OKAY : ccpu_pkg::RESP_SLVERR;
         end
         else if (S_AXI_RREADY)
            S_AXI_RVALID <= 1'b0;
      end
   end
endmodule

// File: verification/capture_compare_pwm_unit_tb.sv
/*
 self-checking bench: register access, capture, compare and pwm.
 assumes ccpu_top, the pin model and the bound checker are compiled first.
*/
`timescale 1ns/10ps
module capture_compare_pwm_unit_tb;
   localparam logic [9:0] A_LO = ccpu_pkg::ADDR_VALUE_LOW;
   localparam logic [9:0] A_HI = ccpu_pkg::ADDR_VALUE_HIGH;
   localparam logic [9:0] A_MD = ccpu_pkg::ADDR_MODE_CTL;
   localparam logic [9:0] A_FL = ccpu_pkg::ADDR_FLAG_STATUS;
   logic clk, srst, awv, wv, bready, arv, rready, tick, dir_in, pdata, ext;
   logic awr, wrdy, bv, arr, rv, pout, oe_n, trig, flag, pin;
   logic [9:0] awa, ara;
   logic [31:0] wd, rdat, rdata;
   logic [15:0] tb16;
   logic [7:0] tb8, per;
   logic [1:0] sub, bresp, rresp;
   int bad_count, n_compared, trigs, hi;
   logic [7:0] cm [7] = '{8'h08, 8'h09, 8'h08, 8'h0A, 8'h00, 8'h0A, 8'h0B};
   logic [31:0] ce [7] = '{1, 0, 1, 1, 0, 0, 0};
   logic [7:0] pl [4] = '{8'h02, 8'h00, 8'hFF, 8'h01};
   logic [7:0] pm [4] = '{8'h0C, 8'h0C, 8'h0C, 8'h2C};
   // high cycles in two 16-cycle periods: duty plus the one-cycle compare response
   logic [31:0] pe [4] = '{18, 0, 32, 14};
   ccpu_top dut (
      .CLK_SYS(clk), .SRST(srst), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_AWADDR(awa), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd),
      .S_AXI_WSTRB(4'h1), .S_AXI_BVALID(bv), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
      .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv),
      .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .TB16_COUNT(tb16),
      .TB8_COUNT(tb8), .TB8_PERIOD(per), .TB8_TICK(tick), .TB8_SUBCOUNT(sub),
      .PORT_DIR_INPUT(dir_in), .PORT_DATA(pdata), .UNIT_PIN_IN(pin), .UNIT_PIN_OUT(pout),
      .UNIT_PIN_OE_N(oe_n), .SPECIAL_TRIGGER(trig), .EVENT_FLAG(flag)
   );
   ccpu_pin_model far (.oe_n(oe_n), .drive(pout), .ext(ext), .level(pin));
   // clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // pwm timebase: four sub-steps per count, wraps at the period
   always @(posedge clk)
   begin
      sub <= sub + 2'h1;
      tick <= (sub == 2'h2);
      if (tick) tb8 <= (tb8 == per) ? 8'h00 : tb8 + 8'h01;
      if (trig) trigs <= trigs + 1;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task wr(input logic [9:0] a, input logic [31:0] d);
      logic ta, tw;
      @(posedge clk);
      {awa, wd} <= {a, d};
      {awv, wv, bready} <= 3'b111;
      {ta, tw} = 2'b00;
      while (!(ta && tw))
      begin
         @(negedge clk);
         {ta, tw} = {ta | awr, tw | wrdy};
         @(posedge clk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      do @(negedge clk); while (!bv);
      @(posedge clk);
      bready <= 1'b0;
   endtask
   task rd(input logic [9:0] a, input logic [31:0] exp);
      @(posedge clk);
      ara <= a;
      {arv, rready} <= 2'b11;
      do @(negedge clk); while (!arr);
      @(posedge clk);
      arv <= 1'b0;
      do @(negedge clk); while (!rv);
      rdat = rdata;
      @(posedge clk);
      rready <= 1'b0;
      chk(rdat, exp);
   endtask
   task pin_to(input logic v);
      @(posedge clk);
      ext <= v;
      cyc(6);
   endtask
   task fchk(input logic [31:0] exp);
      @(negedge clk);
      chk({31'h0, flag}, exp);
   endtask
   // watchdog
   initial
   begin
      cyc(30000);
      bad_count++;
      end_of_test;
   end
   // main sequence
   initial
   begin
      {srst, awv, wv, bready, arv, rready, pdata, ext, sub, tick} = 11'h400;
      {dir_in, tb16, tb8, per, awa, ara, wd, trigs, bad_count, n_compared} = '0;
      dir_in = 1'b1;
      cyc(5);
      srst <= 1'b0;
      rd(A_MD, 32'h0);
      rd(10'h3FC, 32'h0);
      chk(rresp, ccpu_pkg::RESP_SLVERR);
      wr(A_LO, 32'hA5);
      wr(A_HI, 32'h5A);
      chk(bresp, ccpu_pkg::RESP_OKAY);
      wr(10'h3FC, 32'h0);
      chk(bresp, ccpu_pkg::RESP_SLVERR);
      rd(A_LO, 32'hA5);
      rd(A_HI, 32'h5A);
      $display("register test done");
      wr(A_MD, ccpu_pkg::MODE_CAP_RISE);
      tb16 <= 16'h1234;
      pin_to(1'b1);
      fchk(1);
      rd(A_HI, 32'h12);
      pin_to(1'b0);
      tb16 <= 16'h2345;
      pin_to(1'b1);
      rd(A_LO, 32'h45);
      wr(A_FL, 32'h1);
      fchk(0);
      wr(A_MD, ccpu_pkg::MODE_CAP_FALL);
      pin_to(1'b0);
      fchk(1);
      wr(A_FL, 32'h1);
      for (int i = 0; i < 2; i++)
      begin
         wr(A_MD, ccpu_pkg::MODE_OFF);
         wr(A_MD, i ? ccpu_pkg::MODE_CAP_RISE16 : ccpu_pkg::MODE_CAP_RISE4);
         // each pass is one full rising edge on the pad
         repeat (i ? 15 : 3)
         begin
            pin_to(1'b1);
            pin_to(1'b0);
         end
         fchk(0);
         pin_to(1'b0);
         pin_to(1'b1);
         fchk(1);
         pin_to(1'b0);
         wr(A_FL, 32'h1);
      end
      {dir_in, tb16} <= '0;
      wr(A_MD, ccpu_pkg::MODE_CAP_RISE);
      pdata <= 1'b1;
      cyc(6);
      fchk(1);
      @(posedge clk) pdata <= 1'b0;
      $display("capture test done");
      wr(A_LO, 32'h00);
      wr(A_HI, 32'h01);
      wr(A_FL, 32'h1);
      fchk(0);
      for (int i = 0; i < 7; i++)
      begin
         wr(A_MD, cm[i]);
         tb16 <= 16'h0100;
         cyc(4);
         @(negedge clk);
         chk({31'h0, pout}, ce[i]);
         @(posedge clk) tb16 <= 16'h0000;
      end
      fchk(1);
      chk(trigs, 1);
      $display("compare test done");
      per <= 8'h03;
      for (int i = 0; i < 4; i++)
      begin
         wr(A_LO, pl[i]);
         wr(A_MD, pm[i]);
         cyc(40);
         hi = 0;
         repeat (32) @(negedge clk) hi += pout;
         chk(hi, pe[i]);
      end
      rd(A_HI, 32'h01);
      // a long period keeps the next duty reload away from the write and read-back
      per <= 8'hFF;
      wr(A_HI, 32'h77);
      rd(A_HI, 32'h01);
      $display("pwm test done");
      end_of_test;
   end
endmodule

// File: verification/ccpu_monitor.sv
/*
 checker for the register bus, event flag, trigger and pin enable.
 assumes it is bound to ccpu_top and sees only its ports.
*/
`timescale 1ns/10ps
module ccpu_monitor (
   // clock and reset
   input wire logic CLK_SYS,
   input wire logic SRST,
   // register bus
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic S_AXI_ARVALID,
   input wire logic S_AXI_ARREADY,
   input wire logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [31:0] S_AXI_RDATA,
   // unit side
   input wire logic PORT_DIR_INPUT,
   input wire logic UNIT_PIN_OE_N,
   input wire logic SPECIAL_TRIGGER,
   input wire logic EVENT_FLAG
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SRST);
   // bus answers and holds
   AST_WRITE_ANSWER: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
      S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write not answered");
   AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
      else $error("write response dropped");
   AST_ONE_WRITE: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write accepted while response pending");
   AST_READ_ANSWER: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID &&
      S_AXI_RDATA[31:8] == 24'h000000) else $error("read answer wrong");
   AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID &&
      $stable(S_AXI_RDATA)) else $error("read data not held");
   // flag, trigger and pin enable
   AST_FLAG_SW_ONLY: assert property ($fell(EVENT_FLAG) |-> $rose(S_AXI_BVALID))
      else $error("flag cleared without a write");
   AST_TRIG_PULSE: assert property (SPECIAL_TRIGGER |=> !SPECIAL_TRIGGER)
      else $error("trigger longer than one cycle");
   AST_TRIG_FLAG: assert property (SPECIAL_TRIGGER |-> EVENT_FLAG)
      else $error("trigger without flag");
   AST_OE_FOLLOW: assert property (!$past(SRST) |-> UNIT_PIN_OE_N == $past(PORT_DIR_INPUT))
      else $error("pin enable does not follow direction");
endmodule
bind ccpu_top ccpu_monitor mon (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID),
   .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .PORT_DIR_INPUT(PORT_DIR_INPUT), .UNIT_PIN_OE_N(UNIT_PIN_OE_N),
   .SPECIAL_TRIGGER(SPECIAL_TRIGGER), .EVENT_FLAG(EVENT_FLAG)
);

// File: verification/ccpu_pin_model.sv
/*
 far side of the unit pin: an external source that drives the pad level.
 assumes the bench sets the source level and the direction bit.
*/
`timescale 1ns/10ps
module ccpu_pin_model (
   // unit side
   input wire logic oe_n,
   input wire logic drive,
   // outside source and resolved pad
   input wire logic ext,
   output logic level
);
   // the unit drives the pad only when the direction is output
   assign level = oe_n ? ext : drive;
   // the outside source only moves the pad; the timebase runs in sync mode
   // so no asynchronous count is ever presented
endmodule
